/* hw/struct_params_pkg.sv */
package struct_params_pkg;

    // =====================================================
    // Register map
    // =====================================================
    localparam logic [7:0]  STRUCT_PARAMS_OFS = 8'h04;
    localparam logic [31:0] STRUCT_RESET      = 32'h0000_2214;
    localparam logic [31:0] RDATA_RESET       = 32'h0000_0000;
    localparam logic [31:0] RESERVED_MASK     = 32'hFF0E_0060;
    localparam logic [3:0]  ROUTE_RESET       = 4'h0;

    // =====================================================
    // Field positions
    // =====================================================
    localparam int NPORTS_LSB     = 0;
    localparam int PWR_SW_BIT     = 4;
    localparam int ROUTE_RULE_BIT = 7;
    localparam int PER_COMP_LSB   = 8;
    localparam int COMP_CNT_LSB   = 12;
    localparam int PIND_BIT       = 16;
    localparam int DEBUG_LSB      = 20;
    localparam int FIELD_W        = 4;

    // =====================================================
    // Limits and defaults
    // =====================================================
    localparam int MAX_PORTS      = 15;
    localparam int DEF_PORTS      = 4;
    localparam int DEF_PWR_SW     = 1;
    localparam int DEF_COMP_CNT   = 2;
    localparam int DEF_PER_COMP   = 2;
    localparam int DEF_ROUTE_RULE = 0;
    localparam int DEF_PIND       = 0;
    localparam int DEF_DEBUG      = 0;

    // =====================================================
    // Per-port configuration seen by the port registers
    // =====================================================
    typedef struct packed {
        logic [3:0]           n_ports;
        logic [MAX_PORTS-1:0] port_present;
        logic                 power_switched;
        logic                 indicator_ctl;
        logic                 handoff_ok;
        logic [3:0]           debug_port;
    } port_cfg_t;

    // Register read/write request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
    } reg_req_t;

endpackage : struct_params_pkg

/* hw/struct_params.sv */
// Summary of operation
// RULE_01 - Word decoded at byte offset 04h
// RULE_02 - Bits 23:20 name debug port
// RULE_03 - Debug port never exceeds port count
// RULE_04 - Indicator bit enables port indicator field
// RULE_05 - Zero companions: no hand-off, high-speed only
// RULE_06 - Nonzero companions: hand-off supported
// RULE_07 - Ports routed in consecutive companion groups
// RULE_08 - Ports per companion consistent with counts
// RULE_09 - Routing rule 0: ascending function order
// RULE_10 - Routing rule 1: explicit route array
// RULE_11 - Power switch bit reflects switches present
// RULE_12 - Port power field follows power bit
// RULE_13 - Port count sets addressable port registers
// RULE_14 - Port count held within 1h to Fh
// RULE_15 - Read-only; reserved zero; writes ignored
// RULE_16 - Reset word reads 0000_2214
`timescale 1ns/1ns
module struct_params
    import struct_params_pkg::*;
#(
    parameter int N_PORTS               = DEF_PORTS,
    parameter int PORT_POWER_SWITCH_CAP = DEF_PWR_SW,
    parameter int COMPANION_COUNT       = DEF_COMP_CNT,
    parameter int PORTS_PER_COMPANION   = DEF_PER_COMP,
    parameter int PORT_ROUTING_RULE     = DEF_ROUTE_RULE,
    parameter int PORT_INDICATORS       = DEF_PIND,
    parameter int DEBUG_PORT_NUMBER     = DEF_DEBUG,
    // Companion index (0-based) per port, 4 bits each
    parameter logic [MAX_PORTS*4-1:0] COMPANION_ROUTE_ARRAY = '0
) (
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    input  wire reg_req_t          req_i,
    input  wire logic [31:0]       wdata_i,
    output logic [31:0]            rdata_o,
    output logic                   rack_o,
    output port_cfg_t              cfg_o,
    output logic [MAX_PORTS*4-1:0] port_route_o
);

    // =====================================================
    // Elaboration-time field sanitising
    // =====================================================
    // Port count outside 1..15 has no meaning, so pin it
    function automatic int clamp_ports(input int n);
        if (n < 1) begin
            return 1;
        end
        if (n > MAX_PORTS) begin
            return MAX_PORTS;
        end
        return n;
    endfunction : clamp_ports

    // Companion count limited to what its field holds
    function automatic int clamp_comp(input int cc);
        if (cc < 0) begin
            return 0;
        end
        if (cc > MAX_PORTS) begin
            return MAX_PORTS;
        end
        return cc;
    endfunction : clamp_comp

    // Group size large enough to cover every port
    function automatic int fit_per_comp(input int np, input int cc,
                                        input int pc);
        int need;
        need = 0;
        if (cc == 0) begin
            return 0;
        end
        need = (np + cc - 1) / cc;
        if (pc < need) begin
            return need;
        end
        if (pc > MAX_PORTS) begin
            return MAX_PORTS;
        end
        return pc;
    endfunction : fit_per_comp

    // Debug port names an implemented port, or none
    function automatic int fit_debug(input int dp, input int np);
        if (dp < 0 || dp > np) begin
            return 0;
        end
        return dp;
    endfunction : fit_debug

    localparam int EFF_PORTS    = clamp_ports(N_PORTS);          // [RULE_14]
    localparam int EFF_COMP     = clamp_comp(COMPANION_COUNT);
    localparam int EFF_PER_COMP =                                // [RULE_08]
        fit_per_comp(EFF_PORTS, EFF_COMP, PORTS_PER_COMPANION);
    localparam int EFF_DEBUG    =                                // [RULE_03]
        fit_debug(DEBUG_PORT_NUMBER, EFF_PORTS);
    localparam int EFF_RULE     = (PORT_ROUTING_RULE != 0) ? 1 : 0;
    localparam int EFF_PWR_SW   = (PORT_POWER_SWITCH_CAP != 0) ? 1 : 0;
    localparam int EFF_IND      = (PORT_INDICATORS != 0) ? 1 : 0;

    // =====================================================
    // Field values
    // =====================================================
    localparam logic [3:0] FLD_PORTS    = 4'(EFF_PORTS);
    localparam logic [3:0] FLD_PER_COMP = 4'(EFF_PER_COMP);
    localparam logic [3:0] FLD_COMP     = 4'(EFF_COMP);
    localparam logic [3:0] FLD_DEBUG    = 4'(EFF_DEBUG);
    localparam logic       FLD_PWR_SW   = 1'(EFF_PWR_SW);
    localparam logic       FLD_RULE     = 1'(EFF_RULE);
    localparam logic       FLD_IND      = 1'(EFF_IND);

    // =====================================================
    // Assembled word
    // =====================================================
    logic [31:0] nxt_word;

    always_comb begin
        nxt_word = '0;                                        // [RULE_15]
        nxt_word[NPORTS_LSB +: FIELD_W]   = FLD_PORTS;        // [RULE_13]
        nxt_word[PWR_SW_BIT]              = FLD_PWR_SW;       // [RULE_11]
        nxt_word[ROUTE_RULE_BIT]          = FLD_RULE;         // [RULE_09]
        nxt_word[PER_COMP_LSB +: FIELD_W] = FLD_PER_COMP;     // [RULE_08]
        nxt_word[COMP_CNT_LSB +: FIELD_W] = FLD_COMP;         // [RULE_05]
        nxt_word[PIND_BIT]                = FLD_IND;          // [RULE_04]
        nxt_word[DEBUG_LSB +: FIELD_W]    = FLD_DEBUG;        // [RULE_02]
    end

    logic [31:0] word_ff;

    // Starts from the default word, then follows the parameters
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            word_ff <= STRUCT_RESET;                          // [RULE_16]
        end else begin
            word_ff <= nxt_word;
        end
    end

    // =====================================================
    // Register access
    // =====================================================
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b01,
        ACC_ACK  = 2'b10
    } acc_state_t;

    logic       any_req;
    logic       rd_hit;
    logic       rd_miss;
    acc_state_t acc_state_ff;
    acc_state_t nxt_acc_state;

    assign any_req = req_i.rd | req_i.wr;
    assign rd_hit  = req_i.rd & (req_i.addr == STRUCT_PARAMS_OFS); // [RULE_01]
    assign rd_miss = req_i.rd & (req_i.addr != STRUCT_PARAMS_OFS);

    // Every access, writes included, is answered one cycle later
    always_comb begin
        nxt_acc_state = ACC_IDLE;
        case (acc_state_ff)
            ACC_IDLE: begin
                if (any_req) begin
                    nxt_acc_state = ACC_ACK;
                end
            end
            ACC_ACK: begin
                if (any_req) begin
                    nxt_acc_state = ACC_ACK;
                end
            end
            default: begin
                nxt_acc_state = ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_state_ff <= ACC_IDLE;
        end else begin
            acc_state_ff <= nxt_acc_state;
        end
    end

    assign rack_o = (acc_state_ff == ACC_ACK);

    logic [31:0] rdata_ff;

    // Read data holds until the next read; writes never touch it
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_ff <= RDATA_RESET;
        end else if (rd_hit) begin
            rdata_ff <= word_ff & ~RESERVED_MASK;             // [RULE_15]
        end else if (rd_miss) begin
            rdata_ff <= RDATA_RESET;
        end
    end

    assign rdata_o = rdata_ff;

    // =====================================================
    // Configuration to the port registers
    // =====================================================
    logic [3:0]           n_ports_ff;
    logic                 pwr_sw_ff;
    logic                 ind_ff;
    logic                 handoff_ff;
    logic [3:0]           debug_ff;
    logic [MAX_PORTS-1:0] present_bits;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            n_ports_ff <= 4'h0;
        end else begin
            n_ports_ff <= word_ff[NPORTS_LSB +: FIELD_W];     // [RULE_13]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pwr_sw_ff <= 1'b0;
        end else begin
            pwr_sw_ff <= word_ff[PWR_SW_BIT];                 // [RULE_12]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ind_ff <= 1'b0;
        end else begin
            ind_ff <= word_ff[PIND_BIT];                      // [RULE_04]
        end
    end

    // No companions: ports never leave this controller
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            handoff_ff <= 1'b0;
        end else begin
            handoff_ff <=                                     // [RULE_06]
                (word_ff[COMP_CNT_LSB +: FIELD_W] != 4'h0);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            debug_ff <= 4'h0;
        end else begin
            debug_ff <= word_ff[DEBUG_LSB +: FIELD_W];        // [RULE_02]
        end
    end

    // One presence flag per possible port, set for implemented ports
    generate
        for (genvar p = 0; p < MAX_PORTS; p++) begin : g_present
            localparam logic [3:0] PORT_NUM = 4'(p);
            logic bit_ff;

            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    bit_ff <= 1'b0;
                end else begin
                    bit_ff <=                                 // [RULE_13]
                        (PORT_NUM < word_ff[NPORTS_LSB +: FIELD_W]);
                end
            end

            assign present_bits[p] = bit_ff;
        end
    endgenerate

    always_comb begin
        cfg_o.n_ports        = n_ports_ff;
        cfg_o.port_present   = present_bits;
        cfg_o.power_switched = pwr_sw_ff;
        cfg_o.indicator_ctl  = ind_ff;
        cfg_o.handoff_ok     = handoff_ff;
        cfg_o.debug_port     = debug_ff;
    end

    // =====================================================
    // Port-to-companion routing, 1-based, 0 = no companion
    // =====================================================
    generate
        for (genvar p = 0; p < MAX_PORTS; p++) begin : g_route
            localparam int ARR_IDX =
                int'(COMPANION_ROUTE_ARRAY[p*4 +: 4]);
            localparam int SEQ_IDX =
                (EFF_PER_COMP == 0) ? 0 : p / EFF_PER_COMP;
            localparam int SEL_IDX = (EFF_RULE != 0) ? ARR_IDX  // [RULE_10]
                                                     : SEQ_IDX; // [RULE_09]
            localparam int COMP    =
                (p >= EFF_PORTS || EFF_COMP == 0) ? 0 :        // [RULE_05]
                (SEL_IDX >= EFF_COMP) ? 0 : SEL_IDX + 1;       // [RULE_07]
            localparam logic [3:0] ROUTE_VAL = 4'(COMP);
            logic [3:0] route_ff;

            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    route_ff <= ROUTE_RESET;
                end else begin
                    route_ff <= ROUTE_VAL;
                end
            end

            assign port_route_o[p*4 +: 4] = route_ff;
        end
    endgenerate

    // Write data discarded; the word is read-only
    logic unused_wdata;
    assign unused_wdata = ^wdata_i;

endmodule : struct_params

/* tb/struct_params_sva.sv */
`timescale 1ns/1ns
module struct_params_sva
    import struct_params_pkg::*;
(
    input  wire logic                   mclk_i,
    input  wire logic                   srst_i,
    input  wire reg_req_t               req_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic [31:0]            rdata_o,
    input  wire logic                   rack_o,
    input  wire port_cfg_t              cfg_o,
    input  wire logic [MAX_PORTS*4-1:0] port_route_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    a_ack_after_req: assert property (
        (req_i.rd || req_i.wr) |=> rack_o)
        else $error("no ack after request");
    a_ack_cause: assert property (
        rack_o |-> $past(req_i.rd || req_i.wr))
        else $error("ack without request");
    a_read_word: assert property (
        req_i.rd && req_i.addr == STRUCT_PARAMS_OFS
        |=> rdata_o == STRUCT_RESET)
        else $error("word wrong");
    a_read_unmapped: assert property (
        req_i.rd && req_i.addr != STRUCT_PARAMS_OFS
        |=> rdata_o == 32'h0000_0000)
        else $error("unmapped nonzero");
    a_write_ignored: assert property (
        req_i.wr && !req_i.rd |=> $stable(rdata_o))
        else $error("write changed data");
    a_reserved_zero: assert property (
        rack_o && $past(req_i.rd) |->
        rdata_o[31:24] == 8'h00 && rdata_o[19:17] == 3'h0 &&
        rdata_o[6:5] == 2'h0)
        else $error("reserved set");
    a_debug_bound: assert property (
        cfg_o.debug_port <= cfg_o.n_ports)
        else $error("debug port above count");
    a_present_count: assert property (
        $countones(cfg_o.port_present) == int'(cfg_o.n_ports))
        else $error("present mask wrong");
endmodule : struct_params_sva

bind struct_params struct_params_sva struct_params_sva_i (.mclk_i(mclk_i),
    .srst_i(srst_i), .req_i(req_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rack_o(rack_o), .cfg_o(cfg_o), .port_route_o(port_route_o));

/* tb/tb_struct_params.sv */
`timescale 1ns/1ns
module tb_struct_params
    import struct_params_pkg::*;
;
    logic                   mclk_i  = 1'b0;
    logic                   srst_i  = 1'b1;
    reg_req_t               req_i   = '0;
    logic [31:0]            wdata_i = '0;
    logic [31:0]            rdata_o;
    logic                   rack_o;
    port_cfg_t              cfg_o;
    logic [MAX_PORTS*4-1:0] port_route_o;
    logic [31:0]            rng     = 32'h0000_0002;
    logic [31:0]            exp_rd  = '0;
    int                     err_count = 0;
    int                     n_compared = 0;
    int                     n = 4, ncc = 2, npcc = 2, word;
    int                     exp_q[$];
    int                     exp_rt = 0;

    struct_params struct_params_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .req_i(req_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rack_o(rack_o),
        .cfg_o(cfg_o), .port_route_o(port_route_o));

    initial forever #25 mclk_i = ~mclk_i;

    // =====================================================
    // Helpers
    // =====================================================
    function automatic void xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic op(input logic rd, input logic [7:0] a,
                      input logic [31:0] d);
        @(negedge mclk_i);
        req_i <= '{rd: rd, wr: !rd, addr: a};
        wdata_i <= d;
        if (rd) begin
            exp_q.push_back((a == 8'h04) ? word : 0);
        end
        @(negedge mclk_i);
        req_i <= '0;
        if (exp_q.size() > 0) begin
            exp_rd = exp_q.pop_front();
        end
        chk("rack", 1, rack_o);
        chk("rdata", exp_rd, rdata_o);
    endtask : op

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // =====================================================
    // Main sequence
    // =====================================================
    initial begin
        word = n | (1 << 4) | (npcc << 8) | (ncc << 12);
        repeat (10) @(negedge mclk_i);
        srst_i <= 1'b0;
        repeat (3) @(negedge mclk_i);
        chk("rack_idle", 0, rack_o);
        op(1'b1, 8'h04, 32'h0000_0000);
        op(1'b0, 8'h04, 32'hffff_ffff);
        op(1'b1, 8'h04, 32'h0000_0000);
        repeat (60) begin
            xs();
            op(rng[0], (rng[2:1] != 0) ? 8'h04 : rng[15:8], rng);
        end
        chk("ports", n, cfg_o.n_ports);
        chk("present", (1 << n) - 1, cfg_o.port_present);
        chk("power", 1, cfg_o.power_switched);
        chk("indicator", 0, cfg_o.indicator_ctl);
        chk("handoff", ncc > 0, cfg_o.handoff_ok);
        chk("debug", 0, cfg_o.debug_port);
        for (int p = 0; p < MAX_PORTS; p++) begin
            exp_rt = (p < n) ? p / npcc + 1 : 0;
            chk("route", exp_rt, port_route_o[p*4+:4]);
        end
        srst_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        chk("rst_rdata", 0, rdata_o);
        srst_i <= 1'b0;
        op(1'b1, 8'h04, 32'h0000_0000);
        close_out();
    end

    initial begin
        #1000000;
        err_count++;
        close_out();
    end
endmodule : tb_struct_params
